/* File: hw/iad_defines.svh */
/*
 Constants of the indexed address decoder: prefix value, postbyte fields, base and accumulator codes, reset words.
 Assumes it is included by bare name after the package and before the modules that use it.
*/
//Contract
//- No-operand mode takes no bytes after the opcode; operands live in core registers.
//- Inline-operand mode takes one or two following bytes, count fixed by instruction.
//- Page-zero mode takes one address byte; high address byte is zero.
//- Full-address mode takes two bytes forming the whole 16-bit address.
//- Branch-offset mode adds signed 8- or 16-bit displacement to current PC.
//- Short-offset postbyte picks X, Y, SP or PC; low five bits signed offset.
//- Constant-offset postbyte, size clear: 9-bit offset, sign from postbyte bit zero.
//- Size set, sign clear: add 16-bit offset from two extension bytes to base.
//- Size and sign set: add 16-bit offset, fetch pointer there, use as address.
//- Auto-adjust form works on X, Y, SP only; PC code is never a base.
//- Timing bit clear adjusts before use, set adjusts after; step -8..-1, +1..+8.
//- Accumulator offset: code 00 adds A, 01 adds B, 10 adds D, unsigned.
//- Indexed instruction is opcode, postbyte, then zero to two extension bytes.
//- Each opcode value names both instruction and its addressing mode.
//- Prefix byte 0x18 moves the next opcode to the second opcode page.
//- Transfer, exchange and loop postbytes decoded; extension bytes carry their data (code only captures postbyte_ff; count from op_post_ext_len).
//- Multi-byte values and pointers assemble high byte from lower address first.
//- X, Y, SP and PC are 16 bits wide as base addresses.
`ifndef IAD_DEFINES_SVH
`define IAD_DEFINES_SVH

`define IAD_PAGE2_PREFIX 8'h18
`define IAD_BASE_X       2'h0
`define IAD_BASE_Y       2'h1
`define IAD_BASE_SP      2'h2
`define IAD_BASE_PC      2'h3
`define IAD_ACC_A        2'h0
`define IAD_ACC_B        2'h1
`define IAD_ACC_D        2'h2
`define IAD_ACC_DPTR     2'h3
`define IAD_XB_LONG_TOP  3'h7
`define IAD_XB_AUTO_BIT  5
`define IAD_RESET_BYTE   8'h00
`define IAD_RESET_WORD   16'h0000
`define IAD_ONE_WORD     16'h0001

`endif

/* File: hw/iad_pkg.sv */
/*
 Types of the indexed address decoder: opcode classes, addressing modes, sequencer states.
 Assumes the opcode table outside reports a class from iad_class_t for every opcode.
*/
package iad_pkg;

	typedef enum logic [3:0] {
		cls_none,
		cls_inline8,
		cls_inline16,
		cls_page_zero,
		cls_full,
		cls_branch8,
		cls_branch16,
		cls_indexed,
		cls_postbyte
	} iad_class_t;

	typedef enum logic [3:0] {
		no_operand_mode,
		inline_operand_mode,
		page_zero_mode,
		full_address_mode,
		branch_offset_mode,
		indexed_mode,
		indexed_short_extension_mode,
		indexed_long_extension_mode,
		indexed_pointer_mode,
		accumulator_pointer_mode,
		postbyte_mode
	} iad_mode_t;

	typedef enum logic [2:0] {
		st_opcode,
		st_classify,
		st_post,
		st_ext,
		st_calc,
		st_ptr,
		st_load,
		st_done
	} iad_state_t;

endpackage : iad_pkg

/* File: hw/iad_word_asm.sv */
/*
 Byte-to-word assembler: shifts bytes in, first byte ends up most significant.
 Assumes clear and load never come in the same cycle; clear wins if they do.
*/
`timescale 1ns/100ps
module iad_word_asm #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rstn,
	// Control
	input  wire logic             clear,
	input  wire logic             load,
	input  wire logic [7:0]       byte_in,
	// Result
	output logic      [WIDTH-1:0] word_ff
);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			word_ff <= '0;
		end else if (clear) begin
			word_ff <= '0;
		end else if (load) begin
			word_ff <= {word_ff[WIDTH-9:0], byte_in};
		end
	end

endmodule : iad_word_asm

/* File: hw/iad_indexed_address_decoder.sv */
/*
 Operand addressing decoder: takes opcode, optional page prefix, postbyte and extension bytes,
 selects the addressing mode and forms the effective address, fetching a pointer where needed.
 Assumes the opcode table answers combinationally from opcode_ff/page2_ff, the core holds
 its registers stable from opcode to done, and memory answers each read with one ack.
*/
`timescale 1ns/100ps
`include "iad_defines.svh"
module iad_indexed_address_decoder (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                rstn,
	// Instruction stream
	input  wire logic                byte_valid,
	input  wire logic [7:0]          byte_data,
	output logic                     byte_ready_ff,
	// Opcode table
	output logic      [7:0]          opcode_ff,
	output logic                     page2_ff,
	input  iad_pkg::iad_class_t      op_class,
	input  wire logic [1:0]          op_post_ext_len,
	// Core registers
	input  wire logic [15:0]         reg_x,
	input  wire logic [15:0]         reg_y,
	input  wire logic [15:0]         reg_sp,
	input  wire logic [15:0]         reg_pc,
	input  wire logic [7:0]          acc_a,
	input  wire logic [7:0]          acc_b,
	// Pointer read
	output logic                     mem_req_ff,
	output logic      [15:0]         mem_addr_ff,
	input  wire logic                mem_ack,
	input  wire logic [7:0]          mem_rdata,
	// Result
	output logic                     done_ff,
	output iad_pkg::iad_mode_t       mode_ff,
	output logic      [15:0]         ea_ff,
	output logic      [15:0]         operand_ff,
	output logic      [7:0]          postbyte_ff,
	output logic                     base_wr_ff,
	output logic      [1:0]          base_sel_ff,
	output logic      [15:0]         base_new_ff
);
	import iad_pkg::*;

	iad_state_t      state_ff;
	iad_state_t      nxt_state;
	iad_class_t      class_ff;
	logic [1:0]      need_ff;
	logic [1:0]      nxt_need;
	logic [1:0]      ext_cnt_ff;
	logic            ptr_cnt_ff;
	logic            take;
	logic            ext_take;
	logic            ptr_take;
	logic [15:0]     ext_word;
	logic [15:0]     ptr_word;
	logic            nxt_ready;
	iad_mode_t       calc_mode;
	logic [15:0]     calc_ea;
	logic [15:0]     calc_base_new;
	logic            calc_wr;
	logic            calc_indirect;
	logic [1:0]      calc_sel;

	// Extension bytes the postbyte calls for
	function automatic logic [1:0] xb_len(input logic [7:0] xb);
		logic [1:0] len;
		len = 2'h0;
		if (xb[7:5] == `IAD_XB_LONG_TOP && !xb[2]) begin
			len = xb[1] ? 2'h2 : 2'h1;
		end
		return len;
	endfunction : xb_len

	// Extension bytes implied by the opcode class
	function automatic logic [1:0] class_len(input iad_class_t cls);
		logic [1:0] len;
		len = 2'h0;
		case (cls)
			cls_inline8, cls_page_zero, cls_branch8: len = 2'h1;
			cls_inline16, cls_full, cls_branch16:    len = 2'h2;
			default:                                 len = 2'h0;
		endcase
		return len;
	endfunction : class_len

	// 16-bit base register selected by a two-bit field
	function automatic logic [15:0] base_of(input logic [1:0] sel);
		logic [15:0] val;
		val = `IAD_RESET_WORD;
		case (sel)
			`IAD_BASE_X:  val = reg_x;
			`IAD_BASE_Y:  val = reg_y;
			`IAD_BASE_SP: val = reg_sp;
			default:      val = reg_pc;
		endcase
		return val;
	endfunction : base_of

	assign take     = byte_valid & byte_ready_ff;
	assign ext_take = take & (state_ff == st_ext);
	assign ptr_take = mem_ack & mem_req_ff;

	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_need  = need_ff;
		case (state_ff)
			st_opcode: begin
				if (take && !(byte_data == `IAD_PAGE2_PREFIX && !page2_ff)) begin
					nxt_state = st_classify;
				end
			end
			st_classify: begin
				nxt_need = class_len(op_class);
				if (op_class == cls_indexed || op_class == cls_postbyte) begin
					nxt_state = st_post;
				end else if (class_len(op_class) == 2'h0) begin
					nxt_state = st_calc;
				end else begin
					nxt_state = st_ext;
				end
			end
			st_post: begin
				if (take) begin
					nxt_need = (class_ff == cls_indexed) ? xb_len(byte_data) : op_post_ext_len;
					if (nxt_need == 2'h0) begin
						nxt_state = st_calc;
					end else begin
						nxt_state = st_ext;
					end
				end
			end
			st_ext: begin
				if (take && ext_cnt_ff == need_ff - 2'h1) begin
					nxt_state = st_calc;
				end
			end
			st_calc: nxt_state = calc_indirect ? st_ptr : st_done;
			st_ptr: begin
				if (ptr_take && ptr_cnt_ff) begin
					nxt_state = st_load;
				end
			end
			st_load: nxt_state = st_done;
			st_done: nxt_state = st_opcode;
			default: nxt_state = st_opcode;
		endcase
	end

	assign nxt_ready = (nxt_state == st_opcode) || (nxt_state == st_post) || (nxt_state == st_ext);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff      <= st_opcode;
			need_ff       <= 2'h0;
			byte_ready_ff <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			need_ff       <= nxt_need;
			byte_ready_ff <= nxt_ready;
		end
	end

	// Opcode, page and class capture
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			opcode_ff <= `IAD_RESET_BYTE;
			page2_ff  <= 1'b0;
			class_ff  <= cls_none;
		end else begin
			if (state_ff == st_opcode && take) begin
				if (byte_data == `IAD_PAGE2_PREFIX && !page2_ff) begin
					page2_ff <= 1'b1;
				end else begin
					opcode_ff <= byte_data;
				end
			end else if (state_ff == st_done) begin
				page2_ff <= 1'b0;
			end
			if (state_ff == st_classify) begin
				class_ff <= op_class;
			end
		end
	end

	// Postbyte and extension count
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			postbyte_ff <= `IAD_RESET_BYTE;
			ext_cnt_ff  <= 2'h0;
		end else begin
			if (state_ff == st_opcode) begin
				postbyte_ff <= `IAD_RESET_BYTE;
			end else if (state_ff == st_post && take) begin
				postbyte_ff <= byte_data;
			end
			if (state_ff != st_ext) begin
				ext_cnt_ff <= 2'h0;
			end else if (take) begin
				ext_cnt_ff <= ext_cnt_ff + 2'h1;
			end
		end
	end

	// Extension bytes, first one most significant
	iad_word_asm #(
		.WIDTH   (16)
	) u_ext_asm (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clear    (state_ff == st_opcode),
		.load     (ext_take),
		.byte_in  (byte_data),
		.word_ff  (ext_word)
	);

	// Pointer bytes, lower address first
	iad_word_asm #(
		.WIDTH   (16)
	) u_ptr_asm (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clear    (state_ff == st_calc),
		.load     (ptr_take),
		.byte_in  (mem_rdata),
		.word_ff  (ptr_word)
	);

	// Address forming
	always_comb begin
		logic [15:0] base;
		logic [15:0] adj;
		logic [3:0]  step;
		logic [15:0] acc_off;
		base          = base_of(postbyte_ff[7:6]);
		adj           = `IAD_RESET_WORD;
		step          = postbyte_ff[3:0];
		// Unsigned: A or B zero-extended, D as the pair
		acc_off       = postbyte_ff[1] ? {acc_a, acc_b} : {8'h00, postbyte_ff[0] ? acc_b : acc_a};
		calc_mode     = no_operand_mode;
		calc_ea       = `IAD_RESET_WORD;
		calc_base_new = `IAD_RESET_WORD;
		calc_wr       = 1'b0;
		calc_indirect = 1'b0;
		calc_sel      = postbyte_ff[7:6];
		case (class_ff)
			cls_inline8, cls_inline16: calc_mode = inline_operand_mode;
			cls_page_zero: begin
				calc_mode = page_zero_mode;
				calc_ea   = {8'h00, ext_word[7:0]};
			end
			cls_full: begin
				calc_mode = full_address_mode;
				calc_ea   = ext_word;
			end
			cls_branch8: begin
				calc_mode = branch_offset_mode;
				calc_ea   = reg_pc + {{8{ext_word[7]}}, ext_word[7:0]};
			end
			cls_branch16: begin
				calc_mode = branch_offset_mode;
				calc_ea   = reg_pc + ext_word;
			end
			cls_postbyte: calc_mode = postbyte_mode;
			cls_indexed: begin
				if (!postbyte_ff[`IAD_XB_AUTO_BIT]) begin
					calc_mode = indexed_mode;
					calc_ea   = base + {{11{postbyte_ff[4]}}, postbyte_ff[4:0]};
				end else if (postbyte_ff[7:5] == `IAD_XB_LONG_TOP) begin
					// Checked ahead of auto-adjust: that is where the PC code of rr1pnnnn lands
					calc_sel = postbyte_ff[4:3];
					base     = base_of(postbyte_ff[4:3]);
					if (!postbyte_ff[2]) begin
						if (!postbyte_ff[1]) begin
							calc_mode = indexed_short_extension_mode;
							calc_ea   = base + {{8{postbyte_ff[0]}}, ext_word[7:0]};
						end else if (!postbyte_ff[0]) begin
							calc_mode = indexed_long_extension_mode;
							calc_ea   = base + ext_word;
						end else begin
							calc_mode     = indexed_pointer_mode;
							calc_ea       = base + ext_word;
							calc_indirect = 1'b1;
						end
					end else begin
						case (postbyte_ff[1:0])
							`IAD_ACC_A, `IAD_ACC_B, `IAD_ACC_D: begin
								calc_mode = indexed_mode;
								calc_ea   = base + acc_off;
							end
							default: begin
								calc_mode     = accumulator_pointer_mode;
								calc_ea       = base + {acc_a, acc_b};
								calc_indirect = 1'b1;
							end
						endcase
					end
				end else begin
					// Step field 0..7 means +1..+8, 8..15 means -8..-1
					adj           = step[3] ? {12'hfff, step} : {12'h000, step} + `IAD_ONE_WORD;
					calc_mode     = indexed_mode;
					calc_base_new = base + adj;
					calc_wr       = 1'b1;
					calc_ea       = postbyte_ff[4] ? base : calc_base_new;
				end
			end
			default: calc_mode = no_operand_mode;
		endcase
	end

	// Pointer read, high byte first at the lower address
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mem_req_ff  <= 1'b0;
			mem_addr_ff <= `IAD_RESET_WORD;
			ptr_cnt_ff  <= 1'b0;
		end else begin
			if (state_ff == st_calc && calc_indirect) begin
				mem_req_ff  <= 1'b1;
				mem_addr_ff <= calc_ea;
				ptr_cnt_ff  <= 1'b0;
			end else if (ptr_take) begin
				if (!ptr_cnt_ff) begin
					mem_addr_ff <= mem_addr_ff + `IAD_ONE_WORD;
					ptr_cnt_ff  <= 1'b1;
				end else begin
					mem_req_ff <= 1'b0;
				end
			end
		end
	end

	// Result registers, held until the next decode reaches st_calc; ea_ff reloads in st_load
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_ff     <= no_operand_mode;
			ea_ff       <= `IAD_RESET_WORD;
			operand_ff  <= `IAD_RESET_WORD;
			base_sel_ff <= `IAD_BASE_X;
			base_new_ff <= `IAD_RESET_WORD;
		end else if (state_ff == st_calc) begin
			mode_ff     <= calc_mode;
			ea_ff       <= calc_ea;
			operand_ff  <= ext_word;
			base_sel_ff <= calc_sel;
			base_new_ff <= calc_base_new;
		end else if (state_ff == st_load) begin
			ea_ff <= ptr_word;
		end
	end

	// Completion and write-back strobes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			done_ff    <= 1'b0;
			base_wr_ff <= 1'b0;
		end else begin
			done_ff    <= (nxt_state == st_done);
			base_wr_ff <= (nxt_state == st_done) && (state_ff == st_calc) && calc_wr;
		end
	end

endmodule : iad_indexed_address_decoder

/* File: sim/iad_assertions.sv */
/*
 Checker for the indexed address decoder: address forms, auto-adjust, pointer reads.
 Assumes the core holds its registers steady from opcode until the done cycle has been sampled.
*/
`timescale 1ns/100ps
module iad_checker (
	// Clock and reset
	input wire logic          core_clk,
	input wire logic          rstn,
	// Core registers
	input wire logic [15:0]   reg_x,
	input wire logic [15:0]   reg_y,
	input wire logic [15:0]   reg_sp,
	input wire logic [15:0]   reg_pc,
	input wire logic [7:0]    acc_a,
	input wire logic [7:0]    acc_b,
	// Pointer read
	input wire logic          mem_req_ff,
	input wire logic [15:0]   mem_addr_ff,
	input wire logic          mem_ack,
	// Result
	input wire logic          done_ff,
	input iad_pkg::iad_mode_t mode_ff,
	input wire logic [15:0]   ea_ff,
	input wire logic [15:0]   operand_ff,
	input wire logic [7:0]    postbyte_ff,
	input wire logic          base_wr_ff,
	input wire logic [1:0]    base_sel_ff,
	input wire logic [15:0]   base_new_ff
);
	import iad_pkg::*;
	logic [15:0] rb [4];
	logic [15:0] stp;
	logic [15:0] acc_off;
	logic        ack_cnt_ff;
	assign rb[0] = reg_x;
	assign rb[1] = reg_y;
	assign rb[2] = reg_sp;
	assign rb[3] = reg_pc;
	assign stp = postbyte_ff[3] ? {12'hfff, postbyte_ff[3:0]} : {12'h000, postbyte_ff[3:0]} + 16'h0001;
	assign acc_off = postbyte_ff[1] ? {acc_a, acc_b} : {8'h00, postbyte_ff[0] ? acc_b : acc_a};
	// Tells first pointer byte from second
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			ack_cnt_ff <= 1'b0;
		else if (!mem_req_ff)
			ack_cnt_ff <= 1'b0;
		else if (mem_ack)
			ack_cnt_ff <= ~ack_cnt_ff;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_first_ack;
		mem_req_ff && mem_ack && !ack_cnt_ff;
	endsequence
	sequence s_second_ack;
		mem_req_ff && mem_ack && ack_cnt_ff;
	endsequence
	sequence s_load_done;
		!mem_req_ff && !done_ff ##1 done_ff;
	endsequence
	chk_short_offset: assert property (
		done_ff && mode_ff == indexed_mode && !postbyte_ff[5]
		|-> ea_ff == rb[postbyte_ff[7:6]] + {{11{postbyte_ff[4]}}, postbyte_ff[4:0]})
		else $error("short offset address wrong");
	chk_acc_offset: assert property (
		done_ff && mode_ff == indexed_mode && postbyte_ff[7:5] == 3'h7 && postbyte_ff[2]
		|-> ea_ff == rb[postbyte_ff[4:3]] + acc_off)
		else $error("accumulator offset address wrong");
	chk_page_zero: assert property (
		done_ff && mode_ff == page_zero_mode |-> ea_ff == {8'h00, operand_ff[7:0]})
		else $error("page zero address wrong");
	chk_full_addr: assert property (
		done_ff && mode_ff == full_address_mode |-> ea_ff == operand_ff)
		else $error("full address wrong");
	chk_auto_no_pc: assert property (
		base_wr_ff |-> base_sel_ff != 2'h3 && done_ff)
		else $error("auto adjust on program counter");
	chk_auto_step: assert property (
		base_wr_ff |-> base_new_ff == rb[base_sel_ff] + stp
		&& ea_ff == (postbyte_ff[4] ? rb[base_sel_ff] : base_new_ff))
		else $error("auto adjust step or timing wrong");
	chk_req_hold: assert property (
		mem_req_ff && !mem_ack |=> mem_req_ff && $stable(mem_addr_ff))
		else $error("pointer request dropped or moved");
	chk_ptr_next: assert property (
		s_first_ack |=> mem_req_ff && mem_addr_ff == $past(mem_addr_ff) + 16'h0001)
		else $error("second pointer byte address wrong");
	chk_ptr_done: assert property (
		s_second_ack |=> s_load_done)
		else $error("pointer fetch did not complete in time");
endmodule : iad_checker

bind iad_indexed_address_decoder iad_checker u_chk (.core_clk, .rstn, .reg_x, .reg_y, .reg_sp, .reg_pc,
	.acc_a, .acc_b, .mem_req_ff, .mem_addr_ff, .mem_ack, .done_ff, .mode_ff, .ea_ff, .operand_ff,
	.postbyte_ff, .base_wr_ff, .base_sel_ff, .base_new_ff);

/* File: sim/iad_mem_model.sv */
/*
 Memory model answering pointer reads, one byte per ack after a chosen wait.
 Assumes requests are held until acked; data is a fixed function of the address.
*/
`timescale 1ns/100ps
module iad_mem_model (
	// Clock
	input wire logic        core_clk,
	// Pointer read
	input wire logic        mem_req,
	input wire logic [15:0] mem_addr,
	output logic            mem_ack,
	output logic [7:0]      mem_rdata,
	// Wait cycles before each ack
	input int               delay
);
	int cnt;
	// Idle data toggles so stale bytes never look valid
	always @(negedge core_clk) begin
		if (mem_req && cnt >= delay) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem_addr[15:8] ^ mem_addr[7:0] ^ 8'h5a;
			cnt <= 0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			cnt <= mem_req ? cnt + 1 : 0;
		end
	end
endmodule : iad_mem_model

/* File: sim/tb_top.sv */
/*
 Self-checking bench for the indexed address decoder: directed postbytes, every class, random stream.
 Assumes the checker bind and the memory model are compiled before it.
*/
`timescale 1ns/100ps
module tb_top;
	import iad_pkg::*;
	logic        core_clk, rstn, byte_valid, byte_ready_ff, page2_ff, mem_req_ff, mem_ack, done_ff, base_wr_ff;
	logic [1:0]  op_post_ext_len, base_sel_ff;
	logic [7:0]  byte_data, opcode_ff, acc_a, acc_b, mem_rdata, postbyte_ff, op;
	logic [15:0] reg_x, reg_y, reg_sp, reg_pc, mem_addr_ff, ea_ff, operand_ff, base_new_ff;
	iad_class_t  op_class;
	iad_mode_t   mode_ff;
	int          n_errors, num_checks, delay, cycles, k;
	logic [7:0]  pbs [15] = '{8'h10, 8'h0f, 8'hdf, 8'h27, 8'h38, 8'h6f, 8'hb8, 8'he3, 8'he7, 8'hff, 8'hf9,
		8'he2, 8'hec, 8'hf5, 8'hf6};
	// Opcode table: low nibble names the class
	assign op_class = iad_class_t'(opcode_ff[3:0] > 4'h8 ? 4'h0 : opcode_ff[3:0]);
	assign op_post_ext_len = opcode_ff[5:4] == 2'h3 ? 2'h2 : opcode_ff[5:4];
	iad_indexed_address_decoder dut (.core_clk, .rstn, .byte_valid, .byte_data, .byte_ready_ff, .opcode_ff,
		.page2_ff, .op_class, .op_post_ext_len, .reg_x, .reg_y, .reg_sp, .reg_pc, .acc_a, .acc_b, .mem_req_ff,
		.mem_addr_ff, .mem_ack, .mem_rdata, .done_ff, .mode_ff, .ea_ff, .operand_ff, .postbyte_ff, .base_wr_ff,
		.base_sel_ff, .base_new_ff);
	iad_mem_model u_mem (.core_clk, .mem_req(mem_req_ff), .mem_addr(mem_addr_ff), .mem_ack, .mem_rdata, .delay);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic send(input logic [7:0] b);
		int i;
		@(negedge core_clk);
		byte_valid = 1'b1;
		byte_data = b;
		for (i = 0; i < 20 && byte_ready_ff !== 1'b1; i++)
			@(negedge core_clk);
		@(posedge core_clk);
	endtask : send
	task automatic run(input logic pre, input logic [7:0] opc, input logic [7:0] pb, input logic [15:0] xw);
		logic [15:0] rb [4];
		logic [15:0] ea;
		logic [15:0] nb;
		logic [15:0] a;
		iad_mode_t   m;
		int          c;
		int          n;
		int          i;
		logic        post;
		logic        wr;
		@(negedge core_clk);
		{reg_x, reg_y, reg_sp, reg_pc} = {$urandom, $urandom};
		{acc_a, acc_b} = 16'($urandom);
		delay = $urandom % 3;
		rb = '{reg_x, reg_y, reg_sp, reg_pc};
		c = opc[3:0] > 4'h8 ? 0 : opc[3:0];
		m = no_operand_mode;
		ea = 16'h0000;
		nb = 16'h0000;
		n = 0;
		post = 1'b0;
		wr = 1'b0;
		case (c)
			1, 2: begin
				m = inline_operand_mode;
				n = c;
			end
			3: begin
				m = page_zero_mode;
				n = 1;
				ea = {8'h00, xw[7:0]};
			end
			4: begin
				m = full_address_mode;
				n = 2;
				ea = xw;
			end
			5, 6: begin
				m = branch_offset_mode;
				n = c - 4;
				ea = reg_pc + (c == 5 ? {{8{xw[7]}}, xw[7:0]} : xw);
			end
			8: begin
				m = postbyte_mode;
				post = 1'b1;
				n = opc[5:4] == 2'h3 ? 2 : opc[5:4];
			end
			7: begin
				m = indexed_mode;
				post = 1'b1;
				if (!pb[5])
					ea = rb[pb[7:6]] + {{11{pb[4]}}, pb[4:0]};
				else if (pb[7:5] != 3'h7) begin
					wr = 1'b1;
					nb = rb[pb[7:6]] + (pb[3] ? {12'hfff, pb[3:0]} : 16'(pb[3:0]) + 16'h0001);
					ea = pb[4] ? rb[pb[7:6]] : nb;
				end else if (!pb[2]) begin
					n = pb[1] ? 2 : 1;
					ea = rb[pb[4:3]] + (pb[1] ? xw : {{8{pb[0]}}, xw[7:0]});
					m = pb[1] ? (pb[0] ? indexed_pointer_mode : indexed_long_extension_mode)
						: indexed_short_extension_mode;
				end else begin
					ea = rb[pb[4:3]] + (pb[1] ? {acc_a, acc_b} : {8'h00, pb[0] ? acc_b : acc_a});
					m = pb[1:0] == 2'h3 ? accumulator_pointer_mode : indexed_mode;
				end
			end
			default: m = no_operand_mode;
		endcase
		if (m == indexed_pointer_mode || m == accumulator_pointer_mode) begin
			a = ea + 16'h0001;
			ea = {ea[15:8] ^ ea[7:0] ^ 8'h5a, a[15:8] ^ a[7:0] ^ 8'h5a};
		end
		if (pre)
			send(8'h18);
		send(opc);
		#1;
		check("opcode", opcode_ff, opc);
		check("page2", page2_ff, pre);
		if (post)
			send(pb);
		if (n == 2)
			send(xw[15:8]);
		if (n > 0)
			send(xw[7:0]);
		@(negedge core_clk);
		byte_valid = 1'b0;
		byte_data = ~byte_data;
		for (i = 0; i < 40 && done_ff !== 1'b1; i++)
			@(posedge core_clk) #1;
		check("done", done_ff, 1'b1);
		check("ready", byte_ready_ff, 1'b0);
		check("ptr req", mem_req_ff, 1'b0);
		check("mode", mode_ff, m);
		check("ea", ea_ff, ea);
		check("postbyte", postbyte_ff, post ? pb : 8'h00);
		if (n > 0)
			check("operand", n == 1 ? {8'h00, operand_ff[7:0]} : operand_ff, n == 1 ? {8'h00, xw[7:0]} : xw);
		check("base write", base_wr_ff, wr);
		if (wr)
			check("base new", base_new_ff, nb);
		if (wr)
			check("base sel", base_sel_ff, pb[7:6]);
		@(posedge core_clk);
	endtask : run
	initial begin
		rstn = 1'b0;
		byte_valid = 1'b0;
		byte_data = 8'h00;
		{reg_x, reg_y, reg_sp, reg_pc, acc_a, acc_b} = '0;
		{delay, cycles, n_errors, num_checks} = '0;
		void'($urandom(11));
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		foreach (pbs[i])
			run(i[0], 8'h07, pbs[i], 16'($urandom));
		$display("test indexed forms done, mismatches %0d", n_errors);
		for (k = 0; k < 9; k++)
			run(1'b1, 8'(k), 8'($urandom), 16'($urandom));
		$display("test class sweep done, mismatches %0d", n_errors);
		for (k = 0; k < 300; k++) begin
			op = 8'($urandom);
			if (op[3:0] > 4'h8)
				op[3:0] = 4'h7;
			run($urandom % 4 == 0 || op == 8'h18, op, 8'($urandom), 16'($urandom));
		end
		$display("test random stream done, mismatches %0d", n_errors);
		final_report();
	end
endmodule : tb_top
